/* File: hw/bmc_top.sv */
// Notes on behaviour
// - Writing 1 to bit 5 of the mode register enters stream mode.
// - Word is R/W flag bit 15, address bits 14:8, data bits 7:0.
// - Disabled bits do nothing when written; unused registers hold no function.
// - Response field bits 3:2 pick responses 1 to 4, default 00.
// - Rate field bits 1:0: full, half, quarter bit clock; code 10 reserved.
// - Detect status bits 2:1 and zero flags bits 1:0 are read-only.
module bmc_top
	import bmc_pkg::*;
#(
	parameter int ZERO_RUN = 1024,
	parameter int CLK_LOSS = 64
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// Serial control port
	input wire logic ctrl_sel_n,
	input wire logic ctrl_clk,
	input wire logic ctrl_din,
	output logic ctrl_dout,
	output logic ctrl_dout_oe,
	// Stream input
	input wire logic stream_bit_clock,
	input wire logic left_stream_input,
	input wire logic right_stream_input,
	// Controls to the converter
	output bmc_cfg_s cfg,
	output bmc_rate_e fir_rate_active,
	output logic fir_tick,
	output logic [1:0] stream_detect_bits,
	output logic right_zero_flag,
	output logic left_zero_flag
);

	localparam int ZW = $clog2(ZERO_RUN + 1);
	localparam int LW = $clog2(CLK_LOSS + 1);

	// ==========================================================
	// Pin synchronisers
	logic [5:0] sync_a;
	logic [5:0] sync_b;
	logic [5:0] sync_c;
	wire [5:0] pins = {ctrl_sel_n, ctrl_clk, ctrl_din, stream_bit_clock,
		left_stream_input, right_stream_input};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_a <= 6'h3F;
			sync_b <= 6'h3F;
			sync_c <= 6'h3F;
		end else if (ce) begin
			sync_a <= pins;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	wire sel = ~sync_b[5];
	wire sclk_rise = sync_b[4] & ~sync_c[4];
	wire din = sync_b[3];
	wire bclk_rise = sync_b[2] & ~sync_c[2];
	wire left_bit = sync_b[1];
	wire right_bit = sync_b[0];

	// ==========================================================
	// Serial word assembly
	logic [4:0] bit_cnt;
	logic [6:0] shreg;
	logic head_rw;
	logic [6:0] head_addr;
	logic [7:0] rd_sh;

	wire [7:0] word_byte = {shreg, din};
	wire head_done = sel & sclk_rise & (bit_cnt == CNT_HEAD_LAST);
	wire wr_en = sel & sclk_rise & (bit_cnt == CNT_WORD_LAST) & ~head_rw;
	wire [7:0] wdata = word_byte;

	function automatic logic [7:0] read_reg(input logic [6:0] a,
			input bmc_cfg_s c, input logic [1:0] det, input logic zr,
			input logic zl);
		logic [7:0] v;
		v = READ_ZERO;
		case (a)
			ADDR_FIR_RESP: v[POS_RESP_LO +: 2] = c.fir_response_code;
			ADDR_POLARITY: begin
				v[POS_POL] = c.output_polarity_flip;
				v[POS_GATE] = c.output_gate_control;
			end
			ADDR_MODE_RATE: begin
				v[POS_MODE] = c.one_bit_stream_mode;
				v[POS_SINGLE_CHANNEL_SELECT] = c.single_channel_select;
				v[POS_CHANNEL_PICK] = c.channel_pick;
				v[POS_RATE_LO +: 2] = c.fir_rate_code;
			end
			ADDR_DETECT: v[POS_DET_LO +: 2] = det;
			ADDR_ZERO: begin
				v[POS_ZR] = zr;
				v[POS_ZL] = zl;
			end
			default: v = READ_ZERO;
		endcase
		return v;
	endfunction : read_reg

	wire [7:0] rd_word = read_reg(word_byte[6:0], cfg, stream_detect_bits,
		right_zero_flag, left_zero_flag);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt <= 5'h00;
			shreg <= 7'h00;
			head_rw <= 1'b0;
			head_addr <= 7'h00;
			rd_sh <= 8'h00;
		end else if (ce) begin
			if (!sel) begin
				bit_cnt <= 5'h00;
			end else if (sclk_rise && bit_cnt != CNT_WORD_DONE) begin
				bit_cnt <= bit_cnt + 5'h01;
				shreg <= word_byte[6:0];
				rd_sh <= {rd_sh[6:0], 1'b0};
				if (head_done) begin
					head_rw <= word_byte[POS_RW];
					head_addr <= word_byte[6:0];
					rd_sh <= rd_word;
				end
			end
		end
	end

	// Data held in a flop so the pin never glitches mid-bit
	assign ctrl_dout = rd_sh[HEAD_BITS - 1];
	assign ctrl_dout_oe = sel & head_rw & (bit_cnt > CNT_HEAD_LAST)
		& (bit_cnt != CNT_WORD_DONE);

	// ==========================================================
	// Control registers
	// Only enabled bits have storage, so disabled ones cannot act
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg <= CFG_RESET;
		end else if (ce) begin
			cfg.system_restart <= 1'b0;
			if (wr_en) begin
				case (head_addr)
					ADDR_FIR_RESP: cfg.fir_response_code <=
						wdata[POS_RESP_LO +: 2];
					ADDR_POLARITY: begin
						cfg.output_polarity_flip <= wdata[POS_POL];
						cfg.output_gate_control <= wdata[POS_GATE];
					end
					ADDR_MODE_RATE: begin
						cfg.system_restart <= wdata[POS_RESTART];
						cfg.one_bit_stream_mode <= wdata[POS_MODE];
						cfg.single_channel_select <= wdata[POS_SINGLE_CHANNEL_SELECT];
						cfg.channel_pick <= wdata[POS_CHANNEL_PICK];
						if (wdata[POS_RATE_LO +: 2] != RATE_RSVD) begin
							cfg.fir_rate_code <=
								bmc_rate_e'(wdata[POS_RATE_LO +: 2]);
						end
					end
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// Stream clocking and FIR rate
	logic [1:0] div;
	logic [LW-1:0] loss_cnt;
	wire bclk_present = loss_cnt != LW'(CLK_LOSS);
	wire tick_hit = (fir_rate_active == RATE_FULL)
		| ((fir_rate_active == RATE_HALF) & ~div[0])
		| ((fir_rate_active == RATE_QUARTER) & (div == 2'b00));

	// Rate only tracks while out of stream mode, so a late write is inert
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fir_rate_active <= RATE_FULL;
			div <= 2'b00;
			fir_tick <= 1'b0;
			loss_cnt <= LW'(CLK_LOSS);
		end else if (ce) begin
			if (!cfg.one_bit_stream_mode) begin
				fir_rate_active <= cfg.fir_rate_code;
			end
			fir_tick <= cfg.one_bit_stream_mode & bclk_rise & tick_hit;
			if (bclk_rise) begin
				div <= div + 2'b01;
				loss_cnt <= '0;
			end else if (bclk_present) begin
				loss_cnt <= loss_cnt + LW'(1);
			end
		end
	end

	assign stream_detect_bits = {cfg.one_bit_stream_mode & bclk_present,
		bclk_present};

	// ==========================================================
	// Channel zero detection
	function automatic logic [ZW-1:0] run_next(input logic [ZW-1:0] run,
			input logic same);
		if (!same) begin
			return '0;
		end
		return (run == ZW'(ZERO_RUN)) ? run : run + ZW'(1);
	endfunction : run_next

	logic [ZW-1:0] run_l;
	logic [ZW-1:0] run_r;
	logic last_l;
	logic last_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_l <= '0;
			run_r <= '0;
			last_l <= 1'b0;
			last_r <= 1'b0;
		end else if (ce && bclk_rise) begin
			run_l <= run_next(run_l, left_bit == last_l);
			run_r <= run_next(run_r, right_bit == last_r);
			last_l <= left_bit;
			last_r <= right_bit;
		end
	end

	assign left_zero_flag = run_l == ZW'(ZERO_RUN);
	assign right_zero_flag = run_r == ZW'(ZERO_RUN);

	// ==========================================================
	// Checks
	a_mode_enter: assert property (@(posedge clk) disable iff (!reset_n)
		ce && wr_en && head_addr == ADDR_MODE_RATE && wdata[POS_MODE]
		|=> cfg.one_bit_stream_mode)
		else $error("stream mode not entered");
	a_head_take: assert property (@(posedge clk) disable iff (!reset_n)
		ce && head_done |=> head_rw == $past(word_byte[POS_RW])
		&& head_addr == $past(word_byte[6:0]))
		else $error("control header not captured");
	a_resp_store: assert property (@(posedge clk) disable iff (!reset_n)
		ce && wr_en && head_addr == ADDR_FIR_RESP
		|=> cfg.fir_response_code == $past(wdata[POS_RESP_LO +: 2]))
		else $error("response field not stored");
	a_rate_rsvd: assert property (@(posedge clk) disable iff (!reset_n)
		wr_en && wdata[POS_RATE_LO +: 2] == RATE_RSVD
		|=> $stable(cfg.fir_rate_code))
		else $error("reserved rate accepted");
	a_rate_frozen: assert property (@(posedge clk) disable iff (!reset_n)
		cfg.one_bit_stream_mode && $past(cfg.one_bit_stream_mode)
		|-> $stable(fir_rate_active))
		else $error("rate moved in stream mode");
	a_tick_cause: assert property (@(posedge clk) disable iff (!reset_n)
		fir_tick |-> $past(bclk_rise) && $past(cfg.one_bit_stream_mode))
		else $error("tick without bit clock edge");
	a_unused_read: assert property (@(posedge clk) disable iff (!reset_n)
		ce && head_done && word_byte[POS_RW]
		&& (word_byte[6:0] == ADDR_UNUSED_A
		|| word_byte[6:0] == ADDR_UNUSED_B)
		|=> rd_sh == READ_ZERO)
		else $error("unused register reads nonzero");
	a_zero_clear: assert property (@(posedge clk) disable iff (!reset_n)
		ce && bclk_rise && left_bit != last_l |=> !left_zero_flag)
		else $error("zero flag survives toggle");

endmodule : bmc_top

/* File: hw/bmc_pkg.sv */
package bmc_pkg;

	// ==========================================================
	// Control word layout
	localparam int CTRL_WORD_BITS = 16;
	localparam int HEAD_BITS = 8;
	localparam int POS_RW = 7;
	localparam logic [4:0] CNT_HEAD_LAST = 5'h07;
	localparam logic [4:0] CNT_WORD_LAST = 5'h0F;
	localparam logic [4:0] CNT_WORD_DONE = 5'h10;

	// ==========================================================
	// Register addresses
	localparam logic [6:0] ADDR_UNUSED_A = 7'h10;
	localparam logic [6:0] ADDR_UNUSED_B = 7'h11;
	localparam logic [6:0] ADDR_FIR_RESP = 7'h12;
	localparam logic [6:0] ADDR_POLARITY = 7'h13;
	localparam logic [6:0] ADDR_MODE_RATE = 7'h14;
	localparam logic [6:0] ADDR_DETECT = 7'h15;
	localparam logic [6:0] ADDR_ZERO = 7'h16;

	// ==========================================================
	// Field positions
	localparam int POS_RESP_LO = 2;
	localparam int POS_POL = 7;
	localparam int POS_GATE = 4;
	localparam int POS_RESTART = 6;
	localparam int POS_MODE = 5;
	localparam int POS_SINGLE_CHANNEL_SELECT = 3;
	localparam int POS_CHANNEL_PICK = 2;
	localparam int POS_RATE_LO = 0;
	localparam int POS_DET_LO = 1;
	localparam int POS_ZR = 1;
	localparam int POS_ZL = 0;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		RATE_FULL = 2'b00,
		RATE_HALF = 2'b01,
		RATE_RSVD = 2'b10,
		RATE_QUARTER = 2'b11
	} bmc_rate_e;

	typedef struct packed {
		logic one_bit_stream_mode;
		logic system_restart;
		logic single_channel_select;
		logic channel_pick;
		bmc_rate_e fir_rate_code;
		logic [1:0] fir_response_code;
		logic output_polarity_flip;
		logic output_gate_control;
	} bmc_cfg_s;

	localparam bmc_cfg_s CFG_RESET = '{
		one_bit_stream_mode: 1'b0,
		system_restart: 1'b0,
		single_channel_select: 1'b0,
		channel_pick: 1'b0,
		fir_rate_code: RATE_FULL,
		fir_response_code: 2'b00,
		output_polarity_flip: 1'b0,
		output_gate_control: 1'b0
	};

endpackage : bmc_pkg

/* File: bench/bmc_host.sv */
module bmc_host (
	// Clock
	input wire logic clk,
	// Serial control port
	input wire logic ctrl_dout,
	output logic ctrl_sel_n,
	output logic ctrl_clk,
	output logic ctrl_din
);
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// Idle: deselected, link clock standing still
	initial begin
		ctrl_sel_n = 1'b1;
		ctrl_clk = 1'b0;
		ctrl_din = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// ==========================================================
	// One frame, MSB first; fewer than 16 bits aborts it
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [7:0] rd);
		rd = 8'h00;
		tick(1);
		ctrl_sel_n = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			ctrl_din = w[i];
			tick(5);
			if (i < 8) rd[i] = ctrl_dout;
			ctrl_clk = 1'b1;
			tick(5);
			ctrl_clk = 1'b0;
		end
		tick(5);
		ctrl_sel_n = 1'b1;
		// Released line shows no stale bit
		ctrl_din = ~ctrl_din;
		tick(6);
	endtask : xfer
endmodule : bmc_host

/* File: bench/bitstream_mode_control_bank_tb.sv */
module bitstream_mode_control_bank_tb
	import bmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk, reset_n, sbc, sl, sr, sel_n, cclk, din, dout, oe, tk;
	logic zr, zl, run, tog, en;
	// Released line reads inverted, so a stale bit is caught
	wire dout_line = oe ? dout : ~dout;
	logic [1:0] det;
	logic [7:0] rd;
	bmc_cfg_s cfg;
	bmc_rate_e rate;
	int fails, checked, ticks, restarts;

	localparam logic [22:0] ROWS [12] = '{
		{ADDR_UNUSED_A, 8'hFF, 8'h00}, {ADDR_UNUSED_B, 8'hFF, 8'h00},
		{ADDR_FIR_RESP, 8'h00, 8'h00}, {ADDR_FIR_RESP, 8'h04, 8'h04},
		{ADDR_FIR_RESP, 8'h08, 8'h08}, {ADDR_FIR_RESP, 8'hFF, 8'h0C},
		{ADDR_POLARITY, 8'hFF, 8'h90}, {ADDR_MODE_RATE, 8'hD1, 8'h01},
		{ADDR_MODE_RATE, 8'h0E, 8'h0D}, {ADDR_DETECT, 8'hFF, 8'h00},
		{ADDR_ZERO, 8'hFF, 8'h00}, {7'h7F, 8'hFF, 8'h00}};
	localparam logic [1:0] RT [3] = '{2'b00, 2'b01, 2'b11};
	localparam logic [7:0] NT [3] = '{8'h20, 8'h10, 8'h08};

	bmc_top #(.ZERO_RUN(16), .CLK_LOSS(64)) i_dut (.clk(clk),
		.reset_n(reset_n), .ce(en), .ctrl_sel_n(sel_n), .ctrl_clk(cclk),
		.ctrl_din(din), .ctrl_dout(dout), .ctrl_dout_oe(oe),
		.stream_bit_clock(sbc), .left_stream_input(sl),
		.right_stream_input(sr), .cfg(cfg), .fir_rate_active(rate),
		.fir_tick(tk), .stream_detect_bits(det), .right_zero_flag(zr),
		.left_zero_flag(zl));
	bmc_host i_host (.clk(clk), .ctrl_dout(dout_line), .ctrl_sel_n(sel_n),
		.ctrl_clk(cclk), .ctrl_din(din));

	// ==========================================================
	// Clocks; bit clock offset so it never meets a clk edge
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		sbc = 1'b0;
		#3;
		forever begin
			#62.5;
			sbc = run ? ~sbc : 1'b0;
		end
	end
	always @(negedge sbc) if (tog) sl <= ~sl;
	always @(posedge clk) begin
		if (tk) ticks++;
		if (cfg.system_restart) restarts++;
	end

	// ==========================================================
	// Helpers
	task automatic chk(input string nm, input logic [15:0] g, e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_host.xfer({1'b0, a, d}, 16, rd);
	endtask : wr
	task automatic rdr(input logic [6:0] a);
		i_host.xfer({1'b1, a, 8'h00}, 16, rd);
	endtask : rdr
	task automatic finish_test;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	initial begin
		#1ms;
		fails++;
		finish_test();
	end

	// ==========================================================
	// Main sequence
	initial begin
		reset_n = 1'b0;
		{run, tog, sl, sr} = 4'h0;
		en = 1'b1;
		{fails, checked, ticks, restarts} = '0;
		repeat (6) @(posedge clk);
		#1 reset_n = 1'b1;
		chk("cfg reset", 16'(cfg), 16'(CFG_RESET));
		chk("out reset", {rate, det, zr, zl, oe, tk}, 16'h0000);
		repeat (3) @(posedge clk);
		foreach (ROWS[r]) begin
			wr(ROWS[r][22:16], ROWS[r][15:8]);
			rdr(ROWS[r][22:16]);
			chk("readback", rd, ROWS[r][7:0]);
		end
		chk("response", 16'(cfg.fir_response_code), 16'h0003);
		chk("restart", 16'(restarts), 16'h0001);
		i_host.xfer({1'b0, ADDR_FIR_RESP, 8'h04}, 12, rd);
		rdr(ADDR_FIR_RESP);
		chk("aborted", 16'(rd), 16'h000C);
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_MODE_RATE, {6'h00, RT[k]});
			wr(ADDR_MODE_RATE, {6'h08, RT[k]});
			chk("mode", 16'(cfg.one_bit_stream_mode), 16'h0001);
			chk("rate", 16'(rate), 16'(RT[k]));
			run = 1'b1;
			@(negedge sbc);
			ticks = 0;
			repeat (32) @(negedge sbc);
			chk("ticks", 16'(ticks), 16'(NT[k]));
			chk("detect", 16'(det), 16'h0003);
			chk("zero", {zr, zl}, 16'h0003);
			rdr(ADDR_DETECT);
			chk("detect reg", 16'(rd), 16'h0006);
			wr(ADDR_MODE_RATE, 8'h21);
			chk("rate frozen", 16'(rate), 16'(RT[k]));
			run = 1'b0;
			wr(ADDR_MODE_RATE, 8'h00);
		end
		// Left toggles, right stays flat
		run = 1'b1;
		tog = 1'b1;
		repeat (32) @(negedge sbc);
		rdr(ADDR_ZERO);
		chk("zero reg", 16'(rd), 16'h0002);
		run = 1'b0;
		// Enable low must freeze the loss counter
		en = 1'b0;
		repeat (100) @(posedge clk);
		chk("frozen", 16'(det), 16'h0001);
		#1 en = 1'b1;
		repeat (100) @(posedge clk);
		chk("clock lost", 16'(det), 16'h0000);
		finish_test();
	end
endmodule : bitstream_mode_control_bank_tb
